// ### design/reset_ctl_cfg.svh
/*
 * offsets, field positions, reset values and timing counts of the
 * system reset controller. included by the design, the checker and the test.
 */
`ifndef RESET_CTL_CFG_SVH
`define RESET_CTL_CFG_SVH

`define OFS_CAUSE        8'h00
`define OFS_TRIGGER      8'h04
`define OFS_UNLOCK       8'h08
`define OFS_IRQ_STATUS   8'h0c
`define OFS_IRQ_MASK     8'h10

`define BIT_CFG_MISMATCH 9
`define BIT_REG_SLEEP    8
`define BIT_EXT_PIN      7
`define BIT_SOFTWARE     6
`define BIT_WATCHDOG     4
`define BIT_SLEEP_WAKE   3
`define BIT_IDLE_WAKE    2
`define BIT_BROWNOUT     1
`define BIT_POWER_ON     0
`define BIT_TRIGGER      0
`define CAUSE_MASK       32'h0000_03df

`define KEY_FIRST        32'haa99_6655
`define KEY_SECOND       32'h5566_99aa
`define POR_FLAGS        10'h003

`define RST_HOLD_NS      1000
`define CLK_PERIOD_NS    100
`define RST_HOLD_CYC     ((`RST_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ### design/reset_ctl_pkg.sv
/*
 * types of the system reset controller.
 * assumes reset_ctl_cfg.svh is on the include path.
 */
package reset_ctl_pkg;
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} bus_req_s;

	typedef struct packed {
		logic power_on;
		logic clear_pin;
		logic watchdog;
		logic brownout;
		logic cfg_mismatch;
		logic in_sleep;
		logic in_idle;
	} sources_s;

	typedef enum logic [1:0] {LOCKED, KEY1_SEEN, UNLOCKED} lock_e;
	typedef enum logic [1:0] {RUN, HOLD} rst_e;
endpackage

// ### design/system_reset_controller.sv
/*
 * system reset controller: merges reset sources into one master system
 * reset, keeps sticky cause and wake flags, software reset trigger behind
 * an unlock sequence, event interrupt with status and mask.
 * assumes: RESETN is the power-on reset (asynchronous, active low); the
 * other sources are asynchronous levels from detectors; register bus is
 * synchronous to CLK.
 */
// The strobed register port and the register offsets were left to the implementer.
// Notes on behaviour
// - all reset sources merge into one master system reset output
// - six sources: power-on, clear pin, software, watchdog, brown-out, mismatch
// - configuration mismatch reset sets bit 9; software may write it
// - bit 8 set keeps regulator on in sleep, clear turns it off
// - clear pin reset sets bit 7
// - executed software reset sets bit 6
// - watchdog time-out sets bit 4
// - having been in sleep sets bit 3
// - having been in idle sets bit 2
// - brown-out reset sets bit 1; reads 1 after power-on
// - power-on reset sets bit 0; reads 1 after power-on
// - power-on and brown-out flags stay set until software writes zero
// - bits 31 to 10 and bit 5 read zero, writes ignored
// - writing 1 to trigger bit starts software reset, bit self-clears
// - trigger writes accepted only after unlock sequence completes
`include "reset_ctl_cfg.svh"

module system_reset_controller (
	input  wire logic                    CLK,
	input  wire logic                    RESETN,
	input  wire logic                    CLEAR_PIN_N,
	input  wire logic                    WATCHDOG_TIMEOUT,
	input  wire logic                    BROWNOUT,
	input  wire logic                    CONFIG_MISMATCH,
	input  wire logic                    IN_SLEEP,
	input  wire logic                    IN_IDLE,
	input  wire logic [7:0]              ADDR,
	input  wire logic [31:0]             WDATA,
	input  wire logic                    WR,
	input  wire logic                    RD,
	output logic      [31:0]             RDATA,
	output logic                         MASTER_SYSTEM_RESET,
	output logic                         REGULATOR_ON,
	output logic                         IRQ
);
	import reset_ctl_pkg::*;

	localparam logic [3:0] HOLD_CYC = 4'(`RST_HOLD_CYC);

	typedef struct packed {
		logic [9:0]  cause;
		logic [9:0]  irq_status;
		logic [9:0]  irq_mask;
		lock_e       lock;
		rst_e        rst_state;
		logic [3:0]  hold_cnt;
		logic        sw_req;
		sources_s    src_prev;
		logic [31:0] rdata;
	} state_s;

	logic     [1:0]  por_sync;
	logic            rst_n;
	sources_s        src_meta;
	sources_s        src;
	bus_req_s        req;
	state_s          st;
	state_s          next_st;
	logic     [9:0]  hw_set;
	logic            any_src;
	logic            trig_ok;

	// power-on reset release; only this reset touches the cause flags
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN)
			por_sync <= 2'h0;
		else
			por_sync <= {por_sync[0], 1'b1};
	end
	assign rst_n = por_sync[1];

	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			src_meta <= '0;
			src      <= '0;
		end else begin
			src_meta <= '{power_on: 1'b0, clear_pin: ~CLEAR_PIN_N,
				watchdog: WATCHDOG_TIMEOUT, brownout: BROWNOUT,
				cfg_mismatch: CONFIG_MISMATCH, in_sleep: IN_SLEEP,
				in_idle: IN_IDLE};
			src      <= src_meta;
		end
	end

	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};

	always_comb begin
		next_st = st;
		hw_set  = '0;
		// rising edges of pin, watchdog, brown-out and mismatch set their flags; sleep, idle and sw_req set theirs while high
		hw_set[`BIT_EXT_PIN]      = src.clear_pin & ~st.src_prev.clear_pin;
		hw_set[`BIT_WATCHDOG]     = src.watchdog & ~st.src_prev.watchdog;
		hw_set[`BIT_BROWNOUT]     = src.brownout & ~st.src_prev.brownout;
		hw_set[`BIT_CFG_MISMATCH] =
			src.cfg_mismatch & ~st.src_prev.cfg_mismatch;
		hw_set[`BIT_SLEEP_WAKE]   = src.in_sleep;
		hw_set[`BIT_IDLE_WAKE]    = src.in_idle;
		hw_set[`BIT_SOFTWARE]     = st.sw_req;
		next_st.src_prev = src;
		next_st.sw_req   = 1'b0;
		next_st.rdata    = '0;
		trig_ok = req.wr && req.addr == `OFS_TRIGGER
			&& st.lock == UNLOCKED;

		if (req.wr) begin
			unique case (req.addr)
			`OFS_CAUSE: begin
				// flags written directly, zero clears power-on/brown-out
				next_st.cause = req.wdata[9:0] & 10'(`CAUSE_MASK);
			end
			`OFS_TRIGGER: begin
				if (trig_ok && req.wdata[`BIT_TRIGGER])
					next_st.sw_req = 1'b1;
			end
			`OFS_IRQ_MASK: next_st.irq_mask = req.wdata[9:0] & 10'(`CAUSE_MASK);
			default: ;
			endcase
		end

		// unlock: the two keys in order at the unlock offset; any other unlock or trigger write relocks
		if (req.wr) begin
			if (req.addr == `OFS_UNLOCK && req.wdata == `KEY_FIRST)
				next_st.lock = KEY1_SEEN;
			else if (req.addr == `OFS_UNLOCK && req.wdata == `KEY_SECOND
				&& st.lock == KEY1_SEEN)
				next_st.lock = UNLOCKED;
			else if (req.addr == `OFS_TRIGGER)
				next_st.lock = LOCKED;
			else if (req.addr == `OFS_UNLOCK)
				next_st.lock = LOCKED;
		end

		if (req.rd) begin
			unique case (req.addr)
			`OFS_CAUSE:      next_st.rdata = {22'h0, st.cause};
			`OFS_IRQ_STATUS: begin
				next_st.rdata      = {22'h0, st.irq_status};
				next_st.irq_status = '0;
			end
			`OFS_IRQ_MASK:   next_st.rdata = {22'h0, st.irq_mask};
			default:         next_st.rdata = '0;
			endcase
		end

		// hardware set wins over software write or read clear
		next_st.cause      = next_st.cause | hw_set;
		next_st.irq_status = next_st.irq_status | (hw_set & ~st.cause);

		// master reset hold sequencer
		any_src = src.clear_pin | src.watchdog | src.brownout
			| src.cfg_mismatch | st.sw_req;
		unique case (st.rst_state)
		RUN: begin
			if (any_src) begin
				next_st.rst_state = HOLD;
				next_st.hold_cnt  = HOLD_CYC;
			end
		end
		HOLD: begin
			if (any_src)
				next_st.hold_cnt = HOLD_CYC;
			else if (st.hold_cnt == 4'h1)
				next_st.rst_state = RUN;
			else
				next_st.hold_cnt = st.hold_cnt - 4'h1;
		end
		// unused state code: fall back into a fresh hold
		default: begin
			next_st.rst_state = HOLD;
			next_st.hold_cnt  = HOLD_CYC;
		end
		endcase
		if (st.rst_state == HOLD)
			next_st.lock = LOCKED;
	end

	// reset only by power-on; the master reset hold only relocks the unlock state
	always_ff @(posedge CLK or negedge rst_n) begin
		if (!rst_n) begin
			st            <= '0;
			st.cause      <= `POR_FLAGS;
			st.irq_status <= `POR_FLAGS;
			st.lock       <= LOCKED;
			st.rst_state  <= HOLD;
			st.hold_cnt   <= HOLD_CYC;
		end else begin
			st <= next_st;
		end
	end

	assign RDATA = st.rdata;
	assign MASTER_SYSTEM_RESET = st.rst_state == HOLD || !rst_n;
	assign REGULATOR_ON = st.cause[`BIT_REG_SLEEP] | ~src.in_sleep;
	assign IRQ = |(st.irq_status & st.irq_mask);
endmodule // system_reset_controller

// ### tb/reset_src_model.sv
/* reset source detectors in front of the controller.
   assumes fire is driven just after a rising CLK edge. */
module reset_src_model (
	input  wire logic			CLK,
	input  wire logic [5:0]			fire,
	output reset_ctl_pkg::sources_s	src
);
	timeunit 1ns;
	timeprecision 1ns;
	// no power-on pulse: RESETN stands for it
	assign src = {1'b0, fire};
endmodule // reset_src_model

// ### tb/system_reset_controller_assertions.sv
/* port checks of the system reset controller.
   assumes it is bound onto system_reset_controller. */
`include "reset_ctl_cfg.svh"
module system_reset_controller_assertions (
	input wire logic	CLK,
	input wire logic	RESETN,
	input wire logic	CLEAR_PIN_N,
	input wire logic	WATCHDOG_TIMEOUT,
	input wire logic	BROWNOUT,
	input wire logic	CONFIG_MISMATCH,
	input wire logic	IN_SLEEP,
	input wire logic [7:0]	ADDR,
	input wire logic [31:0]	WDATA,
	input wire logic	WR,
	input wire logic	RD,
	input wire logic [31:0]	RDATA,
	input wire logic	MASTER_SYSTEM_RESET,
	input wire logic	REGULATOR_ON
);
	logic	k1;
	logic	k2;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	// tracks a completed unlock sequence
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			k1 <= 1'b0;
			k2 <= 1'b0;
		end else if (WR) begin
			k1 <= ADDR == `OFS_UNLOCK && WDATA == `KEY_FIRST;
			k2 <= ADDR == `OFS_UNLOCK && WDATA == `KEY_SECOND && k1;
		end
	end
	a_cause_reserved: assert property (RD && ADDR == `OFS_CAUSE
		|=> (RDATA & ~`CAUSE_MASK) == 32'h0) else $error("reserved bits set");
	a_trigger_reads: assert property (RD && ADDR == `OFS_TRIGGER
		|=> RDATA == 32'h0) else $error("trigger read not zero");
	a_pin_resets: assert property (!CLEAR_PIN_N
		|-> ##[1:4] MASTER_SYSTEM_RESET) else $error("pin no reset");
	a_watchdog_resets: assert property (WATCHDOG_TIMEOUT
		|-> ##[1:4] MASTER_SYSTEM_RESET) else $error("watchdog no reset");
	a_other_resets: assert property (BROWNOUT || CONFIG_MISMATCH
		|-> ##[1:4] MASTER_SYSTEM_RESET) else $error("source no reset");
	a_reset_hold: assert property ($fell(MASTER_SYSTEM_RESET)
		|-> $past(MASTER_SYSTEM_RESET, 10)) else $error("reset too short");
	a_regulator_awake: assert property (!IN_SLEEP [*4]
		|-> REGULATOR_ON) else $error("regulator off awake");
	a_unlocked_trigger: assert property (WR && ADDR == `OFS_TRIGGER
		&& WDATA[0] && k2 |-> ##[1:3] MASTER_SYSTEM_RESET)
		else $error("trigger no reset");
endmodule // system_reset_controller_assertions
bind system_reset_controller system_reset_controller_assertions u_chk (
	.CLK(CLK), .RESETN(RESETN), .CLEAR_PIN_N(CLEAR_PIN_N),
	.WATCHDOG_TIMEOUT(WATCHDOG_TIMEOUT), .BROWNOUT(BROWNOUT),
	.CONFIG_MISMATCH(CONFIG_MISMATCH), .IN_SLEEP(IN_SLEEP), .ADDR(ADDR),
	.WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
	.MASTER_SYSTEM_RESET(MASTER_SYSTEM_RESET), .REGULATOR_ON(REGULATOR_ON));

// ### tb/system_reset_controller_test.sv
/* register-level test of the system reset controller.
   assumes the source model and checker are compiled alongside. */
`include "reset_ctl_cfg.svh"
module system_reset_controller_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic		clk = 0, rst_n = 0, wr = 0, rd = 0;
	logic [7:0]	addr = 8'h00;
	logic [31:0]	wdata = 32'h0, rdata, q;
	logic [5:0]	fire = 6'h00;
	logic		sys_rst, reg_on, irq;
	reset_ctl_pkg::sources_s src;
	int		errors = 0, cmp_count = 0, cyc = 0;
	logic [5:0]	fsel [4] = '{6'h10, 6'h08, 6'h04, 6'h20};
	logic [31:0]	flag [4] = '{32'h10, 32'h2, 32'h200, 32'h80};
	always #50 clk = !clk;
	reset_src_model u_reset_src_model (.CLK(clk), .fire(fire), .src(src));
	system_reset_controller u_system_reset_controller (.CLK(clk),
		.RESETN(rst_n), .CLEAR_PIN_N(!src.clear_pin),
		.WATCHDOG_TIMEOUT(src.watchdog), .BROWNOUT(src.brownout),
		.CONFIG_MISMATCH(src.cfg_mismatch), .IN_SLEEP(src.in_sleep),
		.IN_IDLE(src.in_idle), .ADDR(addr), .WDATA(wdata), .WR(wr),
		.RD(rd), .RDATA(rdata), .MASTER_SYSTEM_RESET(sys_rst),
		.REGULATOR_ON(reg_on), .IRQ(irq));
	task automatic chk(input string n, input logic [31:0] e, s);
		cmp_count++;
		if (s !== e) begin
			errors++;
			$display("unexpected %s exp %h got %h", n, e, s);
		end
	endtask
	// strobes stay up so calls run back to back
	task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d);
		wr <= w;
		rd <= !w;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		#1 q = rdata;
	endtask
	task automatic idle(input int n);
		wr <= 0;
		rd <= 0;
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rc(input string n, input logic [7:0] a, input logic [31:0] e);
		acc(0, a, 0);
		idle(1);
		chk(n, e, q);
	endtask
	task automatic wt(input logic [7:0] a, input logic [31:0] d);
		acc(1, a, d);
		idle(1);
	endtask
	task automatic settle;
		repeat (40) if (sys_rst !== 1'b0) idle(1);
		chk("reset", 0, sys_rst);
	endtask
	task automatic tally_and_finish;
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	always @(posedge clk) if (++cyc == 3000) begin
		errors++;
		tally_and_finish;
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		idle(1);
		settle;
		rc("cause", `OFS_CAUSE, 32'h3);
		wt(`OFS_CAUSE, 32'hffff_ffff);
		rc("cause", `OFS_CAUSE, `CAUSE_MASK);
		wt(`OFS_CAUSE, 32'h0);
		rc("cause", `OFS_CAUSE, 32'h0);
		fire <= 6'h02;
		idle(5);
		chk("regulator", 0, reg_on);
		wt(`OFS_CAUSE, 32'h100);
		idle(2);
		chk("regulator", 1, reg_on);
		fire <= 6'h01;
		idle(4);
		fire <= 6'h00;
		rc("cause", `OFS_CAUSE, 32'h10c);
		wt(`OFS_IRQ_MASK, 32'h80);
		wt(`OFS_IRQ_STATUS, 32'h0);
		acc(0, `OFS_IRQ_STATUS, 0);
		for (int k = 0; k < 4; k++) begin
			wt(`OFS_CAUSE, 32'h0);
			fire <= fsel[k];
			idle(3);
			fire <= 6'h00;
			idle(4);
			settle;
			rc("cause", `OFS_CAUSE, flag[k]);
			chk("irq", k == 3, irq);
		end
		rc("status", `OFS_IRQ_STATUS, 32'h292);
		chk("irq", 0, irq);
		wt(`OFS_TRIGGER, 32'h1);
		idle(3);
		chk("locked", 0, sys_rst);
		wt(`OFS_CAUSE, 32'h0);
		acc(1, `OFS_UNLOCK, `KEY_FIRST);
		acc(1, `OFS_UNLOCK, `KEY_SECOND);
		acc(1, `OFS_TRIGGER, 32'h1);
		idle(1);
		chk("sw reset", 1, sys_rst);
		settle;
		rc("cause", `OFS_CAUSE, 32'h40);
		rc("trigger", `OFS_TRIGGER, 32'h0);
		rc("unmapped", 8'h40, 32'h0);
		rst_n <= 0;
		idle(2);
		chk("por reset", 1, sys_rst);
		rst_n <= 1;
		idle(1);
		settle;
		rc("cause", `OFS_CAUSE, 32'h3);
		tally_and_finish;
	end
endmodule // system_reset_controller_test
